// ### src/pps_pkg.sv
// constants and types for the transceiver port status and control registers
// Summary of operation
// - negotiation-complete status bit 6, reset zero
// - link-good status bit 5, reset zero
// - partner abilities in status bits 3 to 0
// - partner flow-control capability in bit 4
// - control bit 7 selects transceiver loopback
// - port 1 loopback turns frames at medium attachment
// - port 2 loopback uses port 1 as monitor
// - control bit 5 isolates transceiver from interface
// - control bit 4 soft reset, self clearing
// - control bit 3 forces link up
// - mode field bits 2 to 0, reset 001
// - mode codes for speed and duplex
// - contents reachable through management serial interface; force, mode and crossover bits are not mapped there
// - control register at 0x2f and 0x3f
// - 0x4f and 0x5f reserved, no function
// - crossover state in status bit 7
// - partner status register at 0x2e and 0x3e
`default_nettype none
package pps_pkg;
  // register map of the byte-wide management access
  localparam logic [7:0] ADDR_P1_STAT = 8'h2e;
  localparam logic [7:0] ADDR_P1_CTRL = 8'h2f;
  localparam logic [7:0] ADDR_P2_STAT = 8'h3e;
  localparam logic [7:0] ADDR_P2_CTRL = 8'h3f;
  localparam logic [7:0] ADDR_P3_CTRL = 8'h4f;
  localparam logic [7:0] ADDR_P4_CTRL = 8'h5f;
  // combined control and status fields
  localparam int CTL_LOOP_BIT  = 7;
  localparam int CTL_RSVD_BIT  = 6;
  localparam int CTL_ISO_BIT   = 5;
  localparam int CTL_RST_BIT   = 4;
  localparam int CTL_FORCE_BIT = 3;
  localparam int MODE_MSB      = 2;
  // partner status fields
  localparam int STS_XOVER_BIT = 7;
  localparam int STS_AN_BIT    = 6;
  localparam int STS_LINK_BIT  = 5;
  localparam int STS_FC_BIT    = 4;
  localparam int STS_ABIL_MSB  = 3;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // standard management register view
  localparam logic [4:0] MII_REG_CTRL    = 5'h00;
  localparam logic [4:0] MII_REG_STAT    = 5'h01;
  localparam logic [4:0] MII_REG_PARTNER = 5'h05;
  localparam int MII_CTL_RST_BIT   = 15;
  localparam int MII_CTL_LOOP_BIT  = 14;
  localparam int MII_CTL_ISO_BIT   = 10;
  localparam int MII_STAT_AN_BIT   = 5;
  localparam int MII_STAT_LINK_BIT = 2;
  localparam int MII_LP_PAUSE_BIT  = 10;
  localparam int MII_LP_ABIL_LSB   = 5;
  // width of the synchronised transceiver status bundle
  localparam int PHY_STAT_W = 10;
  localparam int PS_AN     = 9;
  localparam int PS_LINK   = 8;
  localparam int PS_MDI    = 7;
  localparam int PS_FC     = 6;
  localparam int PS_ABIL   = 2;
  localparam int PS_SPEED  = 1;
  localparam int PS_DUPLEX = 0;
  // soft reset hold time, rounded up to whole cycles
  localparam int CLK_PERIOD_NS    = 20;
  localparam int SOFT_RST_TIME_NS = 1000;
  localparam int SOFT_RST_CYCLES  = (SOFT_RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CNT_W        = 6;
  // operating mode codes
  typedef enum logic [2:0] {
    MODE_RSVD0 = 3'b000,
    MODE_NEG   = 3'b001,
    MODE_10HD  = 3'b010,
    MODE_100HD = 3'b011,
    MODE_RSVD4 = 3'b100,
    MODE_10FD  = 3'b101,
    MODE_100FD = 3'b110,
    MODE_RSVD7 = 3'b111
  } pps_mode_type;
  typedef enum logic [0:0] {
    RST_IDLE = 1'b0,
    RST_BUSY = 1'b1
  } pps_rst_state_type;
endpackage
`default_nettype wire

// ### src/pps_sync.sv
// two-stage synchroniser for a bundle of slow level signals
`timescale 1ns/1ps
`default_nettype none
module pps_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         nrst_in,
  input  wire logic         ce_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else if (ce_in) begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // pps_sync
`default_nettype wire

// ### src/pps_port.sv
// control bits, soft reset and status capture for one transceiver port
`timescale 1ns/1ps
`default_nettype none
module pps_port
  import pps_pkg::*;
(
  input  wire logic                  clk_in,
  input  wire logic                  nrst_in,
  input  wire logic                  ce_in,
  input  wire logic                  ctrl_wr_in,
  input  wire logic [7:0]            ctrl_wdata_in,
  input  wire logic [PHY_STAT_W-1:0] phy_stat_in,
  output logic      [7:0]            status_out,
  output logic                       loopback_out,
  output logic                       isolate_out,
  output logic                       soft_reset_out,
  output logic                       force_link_out,
  output var pps_mode_type           mode_out
);
  pps_rst_state_type      rst_state_d;
  logic [RST_CNT_W-1:0]   rst_cnt_q;
  logic [RST_CNT_W-1:0]   rst_cnt_d;
  logic [7:0]             status_d;
  pps_mode_type           mode_d;
  wire                    rst_req  = ctrl_wr_in & ctrl_wdata_in[CTL_RST_BIT];
  wire                    link_eff = phy_stat_in[PS_LINK] | force_link_out;
  wire                    in_rst   = (soft_reset_out == RST_BUSY);

  // soft reset sequencer; a new request during the hold restarts it
  always_comb begin
    rst_state_d = pps_rst_state_type'(soft_reset_out);
    rst_cnt_d   = rst_cnt_q;
    case (pps_rst_state_type'(soft_reset_out))
      RST_IDLE: begin
        if (rst_req) begin
          rst_state_d = RST_BUSY;
          rst_cnt_d   = RST_CNT_W'(SOFT_RST_CYCLES - 1);
        end
      end
      RST_BUSY: begin
        if (rst_req) begin
          rst_cnt_d = RST_CNT_W'(SOFT_RST_CYCLES - 1);
        end else if (rst_cnt_q == '0) begin
          rst_state_d = RST_IDLE; // self clear
        end else begin
          rst_cnt_d = rst_cnt_q - 1'b1;
        end
      end
      default: begin
        rst_state_d = RST_IDLE;
      end
    endcase
  end

  // mode code from resolved speed and duplex
  always_comb begin
    if (in_rst || !link_eff || (!phy_stat_in[PS_AN] && !force_link_out)) begin
      mode_d = MODE_NEG;
    end else if (phy_stat_in[PS_DUPLEX]) begin
      mode_d = phy_stat_in[PS_SPEED] ? MODE_100FD : MODE_10FD;
    end else begin
      mode_d = phy_stat_in[PS_SPEED] ? MODE_100HD : MODE_10HD;
    end
  end

  // status is held at reset value while the transceiver is in soft reset
  assign status_d = in_rst ? STATUS_RESET :
                    {phy_stat_in[PS_MDI], phy_stat_in[PS_AN], link_eff,
                     phy_stat_in[PS_FC], phy_stat_in[PS_ABIL +: 4]};

  // control register; loopback, isolate and force survive a soft reset
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      loopback_out   <= 1'b0;
      isolate_out    <= 1'b0;
      force_link_out <= 1'b0;
      soft_reset_out <= RST_IDLE;
      rst_cnt_q      <= '0;
      status_out     <= STATUS_RESET;
      mode_out       <= MODE_NEG;
    end else if (ce_in) begin
      if (ctrl_wr_in) begin
        loopback_out   <= ctrl_wdata_in[CTL_LOOP_BIT];
        isolate_out    <= ctrl_wdata_in[CTL_ISO_BIT];
        force_link_out <= ctrl_wdata_in[CTL_FORCE_BIT];
      end
      soft_reset_out <= rst_state_d;
      rst_cnt_q      <= rst_cnt_d;
      status_out     <= status_d;
      mode_out       <= mode_d;
    end
  end
endmodule // pps_port
`default_nettype wire

// ### src/pps_top.sv
// register bank for the two transceiver ports with management access
`timescale 1ns/1ps
`default_nettype none
module pps_top
  import pps_pkg::*;
(
  input  wire logic                    clk_in,
  input  wire logic                    nrst_in,
  input  wire logic                    ce_in,
  // switch management byte access
  input  wire logic                    reg_wr_in,
  input  wire logic                    reg_rd_in,
  input  wire logic [7:0]              reg_addr_in,
  input  wire logic [7:0]              reg_wdata_in,
  output logic      [7:0]              reg_rdata_out,
  output logic                         reg_rvalid_out,
  // standard management register access
  input  wire logic                    miim_wr_in,
  input  wire logic                    miim_rd_in,
  input  wire logic                    miim_port_in,
  input  wire logic [4:0]              miim_reg_in,
  input  wire logic [15:0]             miim_wdata_in,
  output logic      [15:0]             miim_rdata_out,
  output logic                         miim_rvalid_out,
  // transceiver status from the analog side, port 1 in the low half
  input  wire logic [2*PHY_STAT_W-1:0] phy_stat_in,
  // receive interface from transceiver towards the switch
  input  wire logic [1:0]              phy_rx_dv_in,
  input  wire logic [7:0]              phy_rxd_in,
  output logic      [1:0]              mac_rx_dv_out,
  output logic      [7:0]              mac_rxd_out,
  // transmit interface from switch towards transceiver
  input  wire logic [1:0]              mac_tx_en_in,
  input  wire logic [7:0]              mac_txd_in,
  output logic      [1:0]              phy_tx_en_out,
  output logic      [7:0]              phy_txd_out,
  // transceiver controls
  output logic      [1:0]              transceiver_loopback_out,
  output logic      [1:0]              transceiver_isolation_out,
  output logic      [1:0]              phy_soft_reset_out,
  output logic      [1:0]              phy_force_link_out
);
  logic [2*PHY_STAT_W-1:0] stat_sync;
  logic [7:0]              status     [2];
  pps_mode_type            mode       [2];
  logic [7:0]              ctrl_rd    [2];
  logic [15:0]             mii_rd     [2];
  logic [1:0]              ctrl_wr;
  logic [7:0]              ctrl_wdata [2];
  logic [7:0]              reg_rdata_d;
  logic [15:0]             miim_rdata_d;

  // status pins come from the analog clock domain
  pps_sync #(
    .W (2*PHY_STAT_W)
  ) u_sync (
    .clk_in   (clk_in),
    .nrst_in  (nrst_in),
    .ce_in    (ce_in),
    .async_in (phy_stat_in),
    .sync_out (stat_sync)
  );

  // byte-bus decode; 0x4f and 0x5f fall through to zero
  wire hit_p1_ctrl = (reg_addr_in == ADDR_P1_CTRL);
  wire hit_p2_ctrl = (reg_addr_in == ADDR_P2_CTRL);
  wire hit_p1_stat = (reg_addr_in == ADDR_P1_STAT);
  wire hit_p2_stat = (reg_addr_in == ADDR_P2_STAT);
  wire miim_ctrl   = miim_wr_in & (miim_reg_in == MII_REG_CTRL);

  genvar gp;
  generate
    for (gp = 0; gp < 2; gp++) begin : g_port
      wire bus_wr  = reg_wr_in & (gp == 0 ? hit_p1_ctrl : hit_p2_ctrl);
      wire mii_sel = miim_ctrl & (miim_port_in == 1'(gp));
      // byte bus wins when both paths write the same port together
      assign ctrl_wr[gp]    = bus_wr | mii_sel;
      assign ctrl_wdata[gp] = bus_wr ? reg_wdata_in :
                              {miim_wdata_in[MII_CTL_LOOP_BIT], 1'b0,
                               miim_wdata_in[MII_CTL_ISO_BIT],
                               miim_wdata_in[MII_CTL_RST_BIT],
                               phy_force_link_out[gp], 3'b000};
      // reserved bit 6 always reads zero
      assign ctrl_rd[gp] = {transceiver_loopback_out[gp], 1'b0,
                            transceiver_isolation_out[gp], phy_soft_reset_out[gp],
                            phy_force_link_out[gp], mode[gp]};

      pps_port u_port (
        .clk_in         (clk_in),
        .nrst_in        (nrst_in),
        .ce_in          (ce_in),
        .ctrl_wr_in     (ctrl_wr[gp]),
        .ctrl_wdata_in  (ctrl_wdata[gp]),
        .phy_stat_in    (stat_sync[gp*PHY_STAT_W +: PHY_STAT_W]),
        .status_out     (status[gp]),
        .loopback_out   (transceiver_loopback_out[gp]),
        .isolate_out    (transceiver_isolation_out[gp]),
        .soft_reset_out (phy_soft_reset_out[gp]),
        .force_link_out (phy_force_link_out[gp]),
        .mode_out       (mode[gp])
      );

      // standard register view of this port
      always_comb begin
        mii_rd[gp] = 16'h0000;
        case (miim_reg_in)
          MII_REG_CTRL: begin
            mii_rd[gp][MII_CTL_RST_BIT]  = phy_soft_reset_out[gp];
            mii_rd[gp][MII_CTL_LOOP_BIT] = transceiver_loopback_out[gp];
            mii_rd[gp][MII_CTL_ISO_BIT]  = transceiver_isolation_out[gp];
          end
          MII_REG_STAT: begin
            mii_rd[gp][MII_STAT_AN_BIT]   = status[gp][STS_AN_BIT];
            mii_rd[gp][MII_STAT_LINK_BIT] = status[gp][STS_LINK_BIT];
          end
          MII_REG_PARTNER: begin
            mii_rd[gp][MII_LP_PAUSE_BIT]          = status[gp][STS_FC_BIT];
            mii_rd[gp][MII_LP_ABIL_LSB +: 4]      = status[gp][STS_ABIL_MSB:0];
          end
          default: begin
            mii_rd[gp] = 16'h0000;
          end
        endcase
      end

      // isolation drops the interface in both directions
      always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
          mac_rx_dv_out[gp]         <= 1'b0;
          mac_rxd_out[gp*4 +: 4]    <= 4'h0;
          phy_tx_en_out[gp]         <= 1'b0;
          phy_txd_out[gp*4 +: 4]    <= 4'h0;
        end else if (ce_in) begin
          mac_rx_dv_out[gp]      <= phy_rx_dv_in[gp] & ~transceiver_isolation_out[gp];
          mac_rxd_out[gp*4 +: 4] <= transceiver_isolation_out[gp] ? 4'h0
                                                                  : phy_rxd_in[gp*4 +: 4];
          phy_tx_en_out[gp]      <= mac_tx_en_in[gp] & ~transceiver_isolation_out[gp];
          phy_txd_out[gp*4 +: 4] <= transceiver_isolation_out[gp] ? 4'h0
                                                                  : mac_txd_in[gp*4 +: 4];
        end
      end
    end
  endgenerate

  // read select; unmapped and reserved addresses read zero
  assign reg_rdata_d = hit_p1_ctrl ? ctrl_rd[0] :
                       hit_p2_ctrl ? ctrl_rd[1] :
                       hit_p1_stat ? status[0]  :
                       hit_p2_stat ? status[1]  : 8'h00;
  assign miim_rdata_d = miim_port_in ? mii_rd[1] : mii_rd[0];

  // read data registered, valid one cycle after the strobe
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      reg_rdata_out   <= 8'h00;
      reg_rvalid_out  <= 1'b0;
      miim_rdata_out  <= 16'h0000;
      miim_rvalid_out <= 1'b0;
    end else if (ce_in) begin
      reg_rvalid_out  <= reg_rd_in;
      miim_rvalid_out <= miim_rd_in;
      if (reg_rd_in) begin
        reg_rdata_out <= reg_rdata_d;
      end
      if (miim_rd_in) begin
        miim_rdata_out <= miim_rdata_d;
      end
    end
  end

  // helper: length of the current soft reset on port 1
  logic [RST_CNT_W:0] p1_rst_len_q;
  always_ff @(posedge clk_in) begin
    if (!nrst_in || !phy_soft_reset_out[0]) begin
      p1_rst_len_q <= '0;
    end else if (ce_in && ctrl_wr[0] && ctrl_wdata[0][CTL_RST_BIT]) begin
      p1_rst_len_q <= '0; // a fresh request restarts the hold, so the count does too
    end else if (ce_in) begin
      p1_rst_len_q <= p1_rst_len_q + 1'b1;
    end
  end

  sequence s_p1_rst_write;
    ce_in && reg_wr_in && hit_p1_ctrl && reg_wdata_in[CTL_RST_BIT];
  endsequence

  sequence s_p1_rst_busy;
    phy_soft_reset_out[0] && status[0] == STATUS_RESET;
  endsequence

  chk_softrst_start: assert property (@(posedge clk_in) disable iff (!nrst_in)
    s_p1_rst_write |=> phy_soft_reset_out[0] ##1 s_p1_rst_busy)
    else $error("soft reset did not start after write");

  chk_softrst_bound: assert property (@(posedge clk_in) disable iff (!nrst_in)
    p1_rst_len_q <= (RST_CNT_W + 1)'(SOFT_RST_CYCLES))
    else $error("soft reset bit did not self clear in time");

  chk_mode_in_rst: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (ce_in && phy_soft_reset_out[1]) |=> mode[1] == MODE_NEG)
    else $error("mode not 001 during soft reset");

  chk_mode_100fd: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (ce_in && !phy_soft_reset_out[0] && stat_sync[PS_LINK] && stat_sync[PS_AN]
     && stat_sync[PS_SPEED] && stat_sync[PS_DUPLEX]) |=> mode[0] == MODE_100FD)
    else $error("mode code wrong for 100 full duplex");

  chk_link_report: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (ce_in && !phy_soft_reset_out[0] && (stat_sync[PS_LINK] || phy_force_link_out[0]))
    |=> status[0][STS_LINK_BIT])
    else $error("link good not reported");

  chk_an_report: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (ce_in && !phy_soft_reset_out[0]) |=> status[0][STS_AN_BIT] == $past(stat_sync[PS_AN]))
    else $error("negotiation complete bit does not follow transceiver");

  chk_isolate_gate: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (ce_in && transceiver_isolation_out[1]) |=> !mac_rx_dv_out[1] && !phy_tx_en_out[1])
    else $error("isolated port still passes interface signals");

  chk_loop_write: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (ce_in && reg_wr_in && hit_p2_ctrl) |=> transceiver_loopback_out[1] == $past(reg_wdata_in[CTL_LOOP_BIT]))
    else $error("loopback bit not taken from write");

  chk_rsvd_read: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (ce_in && reg_rd_in && (reg_addr_in == ADDR_P3_CTRL || hit_p1_ctrl))
    |=> !reg_rdata_out[CTL_RSVD_BIT] && reg_rvalid_out)
    else $error("reserved location or bit read non-zero");

  chk_stat_read: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (ce_in && reg_rd_in && hit_p2_stat) |=> reg_rdata_out == $past(status[1]))
    else $error("partner status read mismatch");
endmodule // pps_top
`default_nettype wire

// ### tb/pps_phy_model.sv
// behavioural transceiver and link partner feeding status pins and receive data
`timescale 1ns/1ps
`default_nettype none
module pps_phy_model
  import pps_pkg::*;
(
  input  wire logic                    clk_in,
  input  wire logic [2*PHY_STAT_W-1:0] cfg_in,
  input  wire logic [1:0]              soft_reset_in,
  output logic      [2*PHY_STAT_W-1:0] phy_stat_out,
  output logic      [1:0]              rx_dv_out,
  output logic      [7:0]              rxd_out
);
  logic [9:0] cnt_q = 10'h000;
  logic [9:0] p1_stat;
  logic [9:0] p2_stat;
  // a transceiver held in soft reset reports no link and no partner abilities
  assign p1_stat = soft_reset_in[0] ? 10'h000 : cfg_in[9:0];
  assign p2_stat = soft_reset_in[1] ? 10'h000 : cfg_in[19:10];
  assign phy_stat_out = {p2_stat, p1_stat};
  // port 1 receive valid changes every cycle, port 2 valid every second and receive data every fourth, so a stale port 1 valid never passes as fresh
  always @(posedge clk_in) begin
    cnt_q <= cnt_q + 10'h001;
  end
  assign rx_dv_out = cnt_q[1:0];
  assign rxd_out   = cnt_q[9:2];
endmodule // pps_phy_model
`default_nettype wire

// ### tb/tb_top.sv
// self-checking bench for the transceiver port status and control registers
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pps_pkg::*;
  logic        clk_in;
  logic        nrst_in = 1'b0;
  logic        ce_in = 1'b1;
  logic        reg_wr_in = 1'b0, reg_rd_in = 1'b0, reg_rvalid_out, miim_rvalid_out;
  logic [7:0]  reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out;
  logic        miim_wr_in = 1'b0, miim_rd_in = 1'b0, miim_port_in = 1'b0;
  logic [4:0]  miim_reg_in = 5'h00;
  logic [15:0] miim_wdata_in = 16'h0000, miim_rdata_out;
  logic [19:0] phy_stat_in, stat_cfg = 20'h00000;
  logic [1:0]  phy_rx_dv_in, mac_rx_dv_out, mac_tx_en_in = 2'h0, phy_tx_en_out;
  logic [7:0]  phy_rxd_in, mac_rxd_out, mac_txd_in = 8'h00, phy_txd_out;
  logic [1:0]  loop_o, iso_o, srst_o, force_o;
  int n_fail = 0, n_compared = 0, n, cfg[2], ctrl[2];
  int mode_tbl[4] = '{2, 5, 3, 6};
  logic [7:0] d, ac[2] = '{ADDR_P1_CTRL, ADDR_P2_CTRL}, as[2] = '{ADDR_P1_STAT, ADDR_P2_STAT};
  logic [15:0] m;
  pps_top i_dut (.clk_in(clk_in), .nrst_in(nrst_in), .ce_in(ce_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out), .miim_wr_in(miim_wr_in),
    .miim_rd_in(miim_rd_in), .miim_port_in(miim_port_in), .miim_reg_in(miim_reg_in),
    .miim_wdata_in(miim_wdata_in), .miim_rdata_out(miim_rdata_out),
    .miim_rvalid_out(miim_rvalid_out), .phy_stat_in(phy_stat_in), .phy_rx_dv_in(phy_rx_dv_in),
    .phy_rxd_in(phy_rxd_in), .mac_rx_dv_out(mac_rx_dv_out), .mac_rxd_out(mac_rxd_out),
    .mac_tx_en_in(mac_tx_en_in), .mac_txd_in(mac_txd_in), .phy_tx_en_out(phy_tx_en_out),
    .phy_txd_out(phy_txd_out), .transceiver_loopback_out(loop_o),
    .transceiver_isolation_out(iso_o), .phy_soft_reset_out(srst_o), .phy_force_link_out(force_o));
  pps_phy_model i_phy (.clk_in(clk_in), .cfg_in(stat_cfg), .soft_reset_in(srst_o),
    .phy_stat_out(phy_stat_in), .rx_dv_out(phy_rx_dv_in), .rxd_out(phy_rxd_in));
  // clock source
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  // hang guard, well above the roughly 900 cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clk_in);
    n_fail++;
    conclude();
  end
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic bw(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_in);
    reg_wr_in <= 1'b1; reg_addr_in <= a; reg_wdata_in <= v;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask
  // read answer is registered: valid right after the edge that takes the strobe
  task automatic br(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_in);
    reg_rd_in <= 1'b1; reg_addr_in <= a;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 check("byte read valid", 16'(reg_rvalid_out), 16'h0001);
    v = reg_rdata_out;
  endtask
  task automatic mx(input logic wr, input logic p, input logic [4:0] r, input logic [15:0] v);
    @(posedge clk_in);
    miim_wr_in <= wr; miim_rd_in <= ~wr; miim_port_in <= p; miim_reg_in <= r; miim_wdata_in <= v;
    @(posedge clk_in);
    miim_wr_in <= 1'b0; miim_rd_in <= 1'b0;
    #1 if (!wr) check("mii read valid", 16'(miim_rvalid_out), 16'h0001);
    m = miim_rdata_out;
  endtask
  function automatic int lk(input int p);
    return ((cfg[p] >> 8) & 1) | ((ctrl[p] >> 3) & 1);
  endfunction
  function automatic logic [15:0] exp_stat(input int p);
    return 16'((((cfg[p] >> 7) & 1) << 7) | (((cfg[p] >> 9) & 1) << 6) | (lk(p) << 5)
               | ((cfg[p] >> 2) & 31));
  endfunction
  // mode falls back to negotiating while link is down or unresolved
  function automatic logic [15:0] exp_ctrl(input int p);
    int md;
    md = (lk(p) == 0 || (((cfg[p] >> 9) & 1) == 0 && ((ctrl[p] >> 3) & 1) == 0)) ? 1
         : mode_tbl[cfg[p] & 3];
    return 16'((ctrl[p] & 8'ha8) | md);
  endfunction
  task automatic chk_regs();
    for (int p = 0; p < 2; p++) begin
      br(as[p], d); check("status", 16'(d), exp_stat(p));
      br(ac[p], d); check("control", 16'(d), exp_ctrl(p));
      check("loopback pin", 16'(loop_o[p]), 16'((ctrl[p] >> 7) & 1));
      check("isolate pin", 16'(iso_o[p]), 16'((ctrl[p] >> 5) & 1));
      check("force pin", 16'(force_o[p]), 16'((ctrl[p] >> 3) & 1));
    end
  endtask
  // data path copy, one cycle late, blanked for an isolated port
  task automatic mii_chk();
    logic [1:0] dv, te, iso;
    logic [7:0] rd, td, msk;
    for (int k = 0; k < 5; k++) begin
      @(posedge clk_in);
      dv = phy_rx_dv_in; rd = phy_rxd_in; te = mac_tx_en_in; td = mac_txd_in;
      mac_tx_en_in <= 2'($urandom); mac_txd_in <= 8'($urandom);
      #1 iso = iso_o;
      msk = {{4{~iso[1]}}, {4{~iso[0]}}};
      check("rx valid", 16'(mac_rx_dv_out), 16'(dv & ~iso));
      check("rx data", 16'(mac_rxd_out), 16'(rd & msk));
      check("tx enable", 16'(phy_tx_en_out), 16'(te & ~iso));
      check("tx data", 16'(phy_txd_out), 16'(td & msk));
    end
  endtask
  initial begin
    void'($urandom(55469));
    cfg = '{0, 0};
    ctrl = '{0, 0};
    repeat (3) @(posedge clk_in);
    nrst_in <= 1'b1;
    chk_regs();
    for (int i = 0; i < 24; i++) begin
      for (int p = 0; p < 2; p++) begin
        cfg[p] = $urandom & 1023;
        if (i == 0) cfg[p] = cfg[p] | 'h303; // one resolved 100 full duplex link up front
        ctrl[p] = $urandom & 8'ha8;
        bw(ac[p], 8'(ctrl[p]));
      end
      stat_cfg <= {10'(cfg[1]), 10'(cfg[0])};
      repeat (5) @(posedge clk_in);
      chk_regs();
      mii_chk();
      // read-only and reserved places ignore writes
      bw(as[i % 2], 8'hff);
      bw(8'(8'h4f + 8'h10 * (i % 2)), 8'hff);
      br(8'(8'h4f + 8'h10 * (i % 2)), d); check("reserved", 16'(d), 16'h0000);
      br(as[i % 2], d); check("status ro", 16'(d), exp_stat(i % 2));
    end
    // clock enable low freezes everything, a loopback and soft reset write included
    @(posedge clk_in);
    ce_in <= 1'b0;
    bw(ac[1], 8'h90);
    ce_in <= 1'b1;
    chk_regs();
    // standard management view
    for (int p = 0; p < 2; p++) begin
      mx(1'b0, p[0], MII_REG_STAT, 16'h0000);
      check("mii status", m, 16'((((cfg[p] >> 9) & 1) << 5) | (lk(p) << 2)));
      mx(1'b0, p[0], MII_REG_PARTNER, 16'h0000);
      check("mii partner", m, 16'((((cfg[p] >> 6) & 1) << 10) | (((cfg[p] >> 2) & 15) << 5)));
      mx(1'b1, p[0], MII_REG_CTRL, 16'h4400);
      ctrl[p] = (ctrl[p] & 8'h08) | 8'ha0;
      mx(1'b0, p[0], MII_REG_CTRL, 16'h0000);
      check("mii control", m, 16'(((ctrl[p] & 8'h80) << 7) | ((ctrl[p] & 8'h20) << 5)));
      mx(1'b0, p[0], 5'h02, 16'h0000);
      check("mii unmapped", m, 16'h0000);
    end
    @(posedge clk_in);
    chk_regs();
    mii_chk();
    // soft reset: self clearing after its hold time
    bw(ADDR_P1_CTRL, 8'(ctrl[0] | 8'h10));
    #1 check("soft reset pin", 16'(srst_o[0]), 16'h0001);
    n = 0;
    while (srst_o[0] === 1'b1 && n < 60) begin
      @(posedge clk_in);
      #1 n++;
    end
    check("soft reset length", 16'(n), 16'(SOFT_RST_CYCLES));
    bw(ADDR_P2_CTRL, 8'(ctrl[1] | 8'h10));
    br(ADDR_P2_CTRL, d); check("ctrl in reset", 16'(d), 16'((ctrl[1] & 8'ha8) | 8'h11));
    br(ADDR_P2_STAT, d); check("status in reset", 16'(d), 16'h0000);
    repeat (60) @(posedge clk_in);
    chk_regs();
    conclude();
  end
endmodule // tb_top
`default_nettype wire
